/* File: logic/trp_pkg.sv */
package trp_pkg;
    typedef logic [47:0] trp_addr_t;
    typedef logic [31:0] trp_cnt_t;
    typedef enum logic [0:0] {
        TRP_STANDBY = 1'b0,
        TRP_ACTIVE = 1'b1
    } trp_role_t;
endpackage

/* File: logic/trp_poll_engine.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "trp_regs.svh"
module trp_poll_engine
    import trp_pkg::*;
#(
    parameter trp_cnt_t POLL_CYC = `TRP_POLL_CYC,
    parameter trp_cnt_t WDOG_CYC = `TRP_WDOG_CYC,
    parameter trp_cnt_t RESP_CYC = `TRP_RESP_CYC
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] insert_phase,
    input wire logic become_active,
    input wire logic purge_done,
    input wire logic enter_ctx,
    input wire logic enter_btx,
    input wire logic rx_valid,
    input wire logic rx_is_amp,
    input wire logic [47:0] rx_src,
    input wire logic rx_ari,
    input wire logic rx_fci,
    output logic amp_req,
    output logic smp_req,
    output logic sua_req,
    output logic fail_req,
    output logic dup_req,
    input wire logic amp_ack,
    input wire logic smp_ack,
    input wire logic sua_ack,
    input wire logic fail_ack,
    input wire logic dup_ack,
    output logic [47:0] tx_src_addr,
    output logic [31:0] tx_drop,
    output logic [47:0] tx_poll_addr,
    output logic [47:0] tx_una,
    output logic [7:0] fail_vector,
    output logic [3:0] fail_class,
    output logic [7:0] sua_vector,
    output logic [3:0] sua_class,
    output logic contention_req,
    output logic discard_all,
    output logic single_station,
    output logic is_active
);
    function automatic trp_cnt_t tick(input trp_cnt_t c);
        tick = (c == 32'h0000_0000) ? 32'h0000_0000 : c - 32'h0000_0001;
    endfunction

    trp_role_t role_r;
    trp_addr_t my_addr_r, una_r, lpa_r;
    logic [31:0] drop_r, errcnt_r;
    logic single_r, complete_r, ariflag_r;
    logic amp_pend_r, smp_pend_r, sua_pend_r, fail_pend_r, dup_pend_r;
    logic ctx_r, discard_r;
    trp_cnt_t poll_cnt_r, wdog_cnt_r, resp_cnt_r;
    trp_cnt_t poll_cnt_nxt, wdog_cnt_nxt, resp_cnt_nxt;

    // Frames before phase 3 are not poll-handled at all
    wire running = insert_phase >= `TRP_PHASE_RUN;
    wire frame = rx_valid && running;
    wire zero = !rx_ari && !rx_fci;
    wire own = rx_src == my_addr_r;
    wire was_am = role_r == TRP_ACTIVE;
    wire foreign_amp = frame && rx_is_amp && was_am && !own;
    wire eff_am = was_am && !foreign_amp;
    wire go = frame && !(eff_am && complete_r);
    // An AMP clears the flag in the same frame, so it cannot count an error
    wire flag_seen = ariflag_r && !rx_is_amp;
    wire hit_zero = go && zero;
    wire err_hit = hit_zero && flag_seen;
    wire poll_exp = eff_am && poll_cnt_r == 32'h0000_0001;
    wire wdog_exp = wdog_cnt_r == 32'h0000_0001;
    wire resp_exp = resp_cnt_r == 32'h0000_0001;
    wire start_poll = (poll_exp || purge_done) && eff_am;
    wire tx_purge = enter_ctx || enter_btx;
    wire wd_restart = frame && rx_is_amp && (eff_am ? own : 1'b1);
    wire start_resp = hit_zero && !eff_am && !flag_seen;

    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire hit_stat = paddr == `TRP_OFF_STATUS;
    wire hit_alo = paddr == `TRP_OFF_ADDR_LO;
    wire hit_ahi = paddr == `TRP_OFF_ADDR_HI;
    wire hit_drop = paddr == `TRP_OFF_DROP;
    wire hit_ulo = paddr == `TRP_OFF_UNA_LO;
    wire hit_uhi = paddr == `TRP_OFF_UNA_HI;
    wire hit_llo = paddr == `TRP_OFF_LPA_LO;
    wire hit_lhi = paddr == `TRP_OFF_LPA_HI;
    wire hit_err = paddr == `TRP_OFF_ERRCNT;
    wire mapped = hit_stat || hit_alo || hit_ahi || hit_drop || hit_ulo || hit_uhi
        || hit_llo || hit_lhi || hit_err;
    wire [31:0] status_word = {25'h0, insert_phase, ariflag_r, was_am, complete_r, single_r};
    wire [31:0] rd_mux = hit_stat ? status_word
        : hit_alo ? my_addr_r[31:0]
        : hit_ahi ? {16'h0, my_addr_r[47:32]}
        : hit_drop ? drop_r
        : hit_ulo ? una_r[31:0]
        : hit_uhi ? {16'h0, una_r[47:32]}
        : hit_llo ? lpa_r[31:0]
        : hit_lhi ? {16'h0, lpa_r[47:32]}
        : hit_err ? errcnt_r : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = apb_acc && !mapped;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            my_addr_r <= `TRP_RST_ADDR;
            drop_r <= `TRP_RST_DROP;
        end
        else
        begin
            if (apb_wr && hit_alo)
                my_addr_r[31:0] <= pwdata;
            if (apb_wr && hit_ahi)
                my_addr_r[47:32] <= pwdata[15:0];
            if (apb_wr && hit_drop)
                drop_r <= pwdata;
        end
    end

    // Role: won contention makes us active; any contention entry or a rival drops it
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            role_r <= TRP_STANDBY;
        else if (foreign_amp || tx_purge)
            role_r <= TRP_STANDBY;
        else if (become_active)
            role_r <= TRP_ACTIVE;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            single_r <= 1'b0;
            complete_r <= 1'b0;
            ariflag_r <= 1'b0;
            una_r <= `TRP_RST_ADDR;
            lpa_r <= `TRP_RST_ADDR;
        end
        else
        begin
            if (frame && !zero)
                single_r <= 1'b0;
            else if (frame && rx_is_amp && eff_am && own && zero)
                single_r <= 1'b1;
            if (hit_zero && eff_am)
                complete_r <= 1'b1;
            else if (start_poll)
                complete_r <= 1'b0;
            if (hit_zero && !flag_seen)
                ariflag_r <= 1'b1;
            else if (frame && rx_is_amp)
                ariflag_r <= 1'b0;
            if (go && !zero)
                lpa_r <= rx_src;
            if (hit_zero && rx_src != una_r)
                una_r <= rx_src;
        end
    end

    // Software write clears the counter; a same-cycle increment still lands
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            errcnt_r <= 32'h0000_0000;
        else if (err_hit)
            errcnt_r <= (apb_wr && hit_err) ? 32'h0000_0001 : errcnt_r + 32'h0000_0001;
        else if (apb_wr && hit_err)
            errcnt_r <= 32'h0000_0000;
    end

    // Poll timer runs only as active monitor; the watchdog serves both roles
    assign poll_cnt_nxt = !eff_am ? 32'h0000_0000
        : (start_poll ? POLL_CYC : tick(poll_cnt_r));
    assign wdog_cnt_nxt = (become_active || foreign_amp || wd_restart) ? WDOG_CYC
        : wdog_exp ? 32'h0000_0000 : tick(wdog_cnt_r);
    assign resp_cnt_nxt = (eff_am || tx_purge) ? 32'h0000_0000
        : start_resp ? RESP_CYC : tick(resp_cnt_r);

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            poll_cnt_r <= 32'h0000_0000;
            wdog_cnt_r <= 32'h0000_0000;
            resp_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            poll_cnt_r <= poll_cnt_nxt;
            wdog_cnt_r <= wdog_cnt_nxt;
            resp_cnt_r <= resp_cnt_nxt;
        end
    end

    // Pending frames; a new queue event wins over an ack in the same cycle.
    // No retry: an ack clears the request whether or not the send worked.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            amp_pend_r <= 1'b0;
            smp_pend_r <= 1'b0;
            sua_pend_r <= 1'b0;
            fail_pend_r <= 1'b0;
            dup_pend_r <= 1'b0;
        end
        else
        begin
            if (start_poll)
                amp_pend_r <= 1'b1;
            else if (tx_purge || amp_ack || discard_r)
                amp_pend_r <= 1'b0;
            if (resp_exp && !eff_am)
                smp_pend_r <= 1'b1;
            else if (tx_purge || (smp_ack && running) || discard_r)
                smp_pend_r <= 1'b0;
            if (hit_zero && rx_src != una_r)
                sua_pend_r <= 1'b1;
            else if ((sua_ack && running) || discard_r)
                sua_pend_r <= 1'b0;
            if (poll_exp && !complete_r)
                fail_pend_r <= 1'b1;
            else if (fail_ack || discard_r)
                fail_pend_r <= 1'b0;
            if (foreign_amp)
                dup_pend_r <= 1'b1;
            else if (dup_ack || discard_r)
                dup_pend_r <= 1'b0;
        end
    end

    // Watchdog loss: active monitor goes to contention, standby also discards
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctx_r <= 1'b0;
            discard_r <= 1'b0;
        end
        else
        begin
            ctx_r <= wdog_exp;
            discard_r <= wdog_exp && !was_am;
        end
    end

    assign amp_req = amp_pend_r;
    assign smp_req = smp_pend_r && running;
    assign sua_req = sua_pend_r && running;
    assign fail_req = fail_pend_r;
    assign dup_req = dup_pend_r;
    assign tx_src_addr = my_addr_r;
    assign tx_drop = drop_r;
    assign tx_poll_addr = lpa_r;
    assign tx_una = una_r;
    assign fail_vector = `TRP_VEC_FAIL;
    assign fail_class = `TRP_CLS_FAIL;
    assign sua_vector = `TRP_VEC_SUA;
    assign sua_class = `TRP_CLS_SUA;
    assign contention_req = ctx_r;
    assign discard_all = discard_r;
    assign single_station = single_r;
    assign is_active = was_am;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    single_set_a: assert property (frame && rx_is_amp && was_am && own && zero
        |=> single_r)
        else $error("single-station not set on lone own AMP");
    single_clr_a: assert property (frame && !zero |=> !single_r)
        else $error("single-station not cleared");
    no_frame_pre3_a: assert property (rx_valid && !running
        |=> $stable(una_r) && $stable(lpa_r))
        else $error("poll frame handled before phase 3");
    complete_set_a: assert property (hit_zero && eff_am |=> complete_r)
        else $error("poll complete not set");
    una_update_a: assert property (hit_zero && rx_src != una_r
        |=> una_r == $past(rx_src) && sua_pend_r)
        else $error("neighbour change not taken");
    err_count_a: assert property (err_hit && !(apb_wr && hit_err)
        |=> errcnt_r == $past(errcnt_r) + 32'h0000_0001)
        else $error("error counter not incremented");
    hold_phase_a: assert property (!running |-> !smp_req && !sua_req)
        else $error("report sent before phase 3");
    purge_q_a: assert property (tx_purge && !start_poll && !(resp_exp && !eff_am)
        |=> !amp_req && !smp_pend_r)
        else $error("poll frames not purged");
    resp_smp_a: assert property (start_resp
        ##1 (!tx_purge && !eff_am && !start_resp)[*2] |-> resp_cnt_r != 32'h0000_0000)
        else $error("response timer not running");
    dup_mon_a: assert property (foreign_amp |=> role_r == TRP_STANDBY && dup_req)
        else $error("duplicate monitor not handled");
    wdog_ctx_a: assert property (wdog_exp |=> contention_req ##1 !contention_req)
        else $error("watchdog expiry not reported");
    // Queue and timer checks; each antecedent excludes the event that would win
    fail_report_a: assert property (poll_exp && !complete_r |=> fail_req)
        else $error("poll failure report not queued");
    poll_start_a: assert property (start_poll && !hit_zero |=> amp_req && !complete_r)
        else $error("poll start did not queue AMP");
    poll_addr_a: assert property (go && !zero |=> lpa_r == $past(rx_src))
        else $error("latest poll address not stored");
    flag_clear_a: assert property (frame && rx_is_amp && !hit_zero |=> !ariflag_r)
        else $error("AMP did not clear the flag");
    flag_set_a: assert property (hit_zero && !flag_seen |=> ariflag_r)
        else $error("flag not set on first zero frame");
    poll_done_a: assert property (frame && eff_am && complete_r
        |=> $stable(una_r) && $stable(lpa_r))
        else $error("handling after poll complete");
    una_keep_a: assert property (frame && !hit_zero |=> $stable(una_r))
        else $error("neighbour changed without zero frame");
    smp_queue_a: assert property (resp_exp && !eff_am |=> smp_pend_r)
        else $error("SMP not queued on response expiry");
    standby_loss_a: assert property (wdog_exp && !was_am |=> discard_all && contention_req)
        else $error("standby watchdog loss not reported");
    discard_queue_a: assert property (discard_r && !frame && !eff_am
        |=> !amp_pend_r && !sua_pend_r && !fail_pend_r && !dup_pend_r)
        else $error("pending frames kept after watchdog loss");
    resp_purge_a: assert property (tx_purge |=> resp_cnt_r == 32'h0000_0000)
        else $error("response timer kept after purge");
    wdog_reload_a: assert property (wd_restart |=> wdog_cnt_r == WDOG_CYC)
        else $error("watchdog not restarted by AMP");

    poll_cycle_c: cover property (start_poll ##[1:1000] hit_zero && eff_am);
    smp_relay_c: cover property (start_resp ##[1:1000] smp_req);
    err_c: cover property (err_hit);
    wdog_c: cover property (wdog_exp);
    fail_c: cover property (fail_req && fail_ack);
endmodule

/* File: logic/trp_regs.svh */
// Functional notes
// - Poll frames carry our 6-byte address and 4-byte physical drop number.
// - Active monitor sends AMP on 7 s poll expiry or purge end; clears complete.
// - Poll frame handling applies only from insertion phase 3 onward.
// - Active monitor seeing own AMP with ARI/FCI zero sets single-station.
// - Any AMP/SMP with ARI/FCI not zero clears single-station.
// - AMP restarts standby receive poll timer and clears receive ARI/FCI flag.
// - Active monitor with poll complete set ignores further poll handling.
// - Non-zero ARI/FCI frame stores its source as latest poll address.
// - Zero ARI/FCI frame with new source updates neighbour and queues report.
// - Flag set means error count increment and no SMP; else flag gets set.
// - Active monitor seeing zero ARI/FCI frame sets poll complete.
// - Standby seeing zero ARI/FCI frame starts 20 ms timer, then queues SMP.
// - Poll timer expiry without completion queues failure report, new poll.
// - Active monitor seeing foreign AMP drops role, reports duplicate monitor.
// - Active monitor needs own AMP within 15 s, else contention transmit.
// - Standby needs AMP within 15 s, else discard pending and contention.
// - Receive poll timer runs only while acting as standby monitor; here the watchdog also runs as active monitor.
// - Neighbour reports and SMP wait until insertion phase 3.
// - Entering contention or beacon transmit purges pending AMP and SMP.
// - Poll frames are never retried; next poll timer expiry restarts polling.
// - Failure report uses vector 27h class 6h; neighbour report vector 26h.
`ifndef TRP_REGS_SVH
`define TRP_REGS_SVH
`define TRP_OFF_STATUS 8'h00
`define TRP_OFF_ADDR_LO 8'h04
`define TRP_OFF_ADDR_HI 8'h08
`define TRP_OFF_DROP 8'h0C
`define TRP_OFF_UNA_LO 8'h10
`define TRP_OFF_UNA_HI 8'h14
`define TRP_OFF_LPA_LO 8'h18
`define TRP_OFF_LPA_HI 8'h1C
`define TRP_OFF_ERRCNT 8'h20
`define TRP_ST_SINGLE 0
`define TRP_ST_COMPLETE 1
`define TRP_ST_ACTIVE 2
`define TRP_ST_ARIFLAG 3
`define TRP_ST_PHASE 4
`define TRP_RST_ADDR 48'h0000_0000_0000
`define TRP_RST_DROP 32'h0000_0000
`define TRP_VEC_FAIL 8'h27
`define TRP_CLS_FAIL 4'h6
`define TRP_VEC_SUA 8'h26
`define TRP_CLS_SUA 4'h4
`define TRP_PHASE_RUN 3'h3
`define TRP_CLK_HZ 40000000
`define TRP_POLL_S 7
`define TRP_WDOG_S 15
`define TRP_RESP_MS 20
`define TRP_POLL_CYC (`TRP_POLL_S * `TRP_CLK_HZ)
`define TRP_WDOG_CYC (`TRP_WDOG_S * `TRP_CLK_HZ)
`define TRP_RESP_CYC (`TRP_RESP_MS * (`TRP_CLK_HZ / 1000))
`endif

/* File: testbench/token_ring_poll_engine_test.sv */
`timescale 1ns/1ps
`include "trp_regs.svh"
module token_ring_poll_engine_test;
    import trp_pkg::*;
    logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0] paddr, fail_vector, sua_vector;
    logic [31:0] pwdata, prdata, tx_drop, q, rnd;
    logic [2:0] insert_phase;
    logic [3:0] ctl, fail_class, sua_class;
    logic [4:0] ack;
    logic rx_valid, rx_is_amp, rx_ari, rx_fci, contention_req, discard_all;
    logic amp_req, smp_req, sua_req, fail_req, dup_req, single_station, is_active;
    trp_addr_t rx_src, tx_src_addr, tx_poll_addr, tx_una, own, sa, sb;
    int fails, n_checks, waited;
    wire [2:0] watch = {contention_req, fail_req, smp_req};

    trp_poll_engine #(.POLL_CYC(200), .WDOG_CYC(500), .RESP_CYC(20)) trp_poll_engine_i (
        .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .insert_phase(insert_phase), .become_active(ctl[0]), .purge_done(ctl[1]),
        .enter_ctx(ctl[2]), .enter_btx(ctl[3]), .rx_valid(rx_valid), .rx_is_amp(rx_is_amp),
        .rx_src(rx_src), .rx_ari(rx_ari), .rx_fci(rx_fci), .amp_req(amp_req),
        .smp_req(smp_req), .sua_req(sua_req), .fail_req(fail_req), .dup_req(dup_req),
        .amp_ack(ack[0]), .smp_ack(ack[1]), .sua_ack(ack[2]), .fail_ack(ack[3]),
        .dup_ack(ack[4]), .tx_src_addr(tx_src_addr), .tx_drop(tx_drop),
        .tx_poll_addr(tx_poll_addr), .tx_una(tx_una), .fail_vector(fail_vector),
        .fail_class(fail_class), .sua_vector(sua_vector), .sua_class(sua_class),
        .contention_req(contention_req), .discard_all(discard_all),
        .single_station(single_station), .is_active(is_active));

    trp_ring_model #(.DLY(3)) trp_ring_model_i (.ref_clk(ref_clk), .reset(reset),
        .req({dup_req, fail_req, sua_req, smp_req, amp_req}), .ack(ack));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic trp_addr_t rnd48();
        rnd = lfsr(lfsr(rnd));
        return {rnd[15:0], lfsr(rnd)};
    endfunction

    function automatic logic [31:0] st(input logic [2:0] ph, input logic [3:0] b);
        return {25'h0000000, ph, b};
    endfunction

    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            fails++;
            final_report();
        end
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic frame(input logic amp, input trp_addr_t src, input logic [1:0] fs);
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_is_amp <= amp;
        rx_src <= src;
        {rx_ari, rx_fci} <= fs;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic pulse(input int b);
        @(posedge ref_clk);
        ctl[b] <= 1'b1;
        @(posedge ref_clk);
        ctl[b] <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic wait_hi(input int b, input int lim);
        waited = 0;
        while (watch[b] !== 1'b1 && waited < lim)
        begin
            @(negedge ref_clk);
            waited++;
        end
        if (waited >= lim)
        begin
            fails++;
            final_report();
        end
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        final_report();
    end

    initial
    begin
        {reset, psel, penable, pwrite, rx_valid, rx_is_amp, rx_ari, rx_fci} = 8'h80;
        {paddr, pwdata, insert_phase, ctl, rx_src} = '0;
        {fails, n_checks, rnd} = {32'h0, 32'h0, 32'hDE68B351};
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        chk({fail_vector, fail_class, sua_vector, sua_class}, {8'h27, 4'h6, 8'h26, 4'h4});
        apb(`TRP_OFF_STATUS, 1'b0, 32'h0);
        chk(q, st(3'h0, 4'h0));
        apb(8'h24, 1'b0, 32'h0);
        chk({perr, q}, {1'b1, 32'h0});
        own = rnd48();
        apb(`TRP_OFF_ADDR_LO, 1'b1, own[31:0]);
        apb(`TRP_OFF_ADDR_HI, 1'b1, {16'h0000, own[47:32]});
        apb(`TRP_OFF_DROP, 1'b1, rnd);
        @(negedge ref_clk);
        chk({tx_src_addr, tx_drop}, {own, rnd});
        apb(`TRP_OFF_ADDR_HI, 1'b0, 32'h0);
        chk(q, {16'h0000, own[47:32]});
        sa = rnd48();
        sb = rnd48();
        insert_phase <= 3'h2;
        frame(1'b0, sa, 2'b00);
        chk({tx_una, sua_req}, 49'h0);
        @(posedge ref_clk);
        insert_phase <= 3'h3;
        frame(1'b0, sa, 2'b00);
        chk({tx_una, sua_req}, {sa, 1'b1});
        apb(`TRP_OFF_STATUS, 1'b0, 32'h0);
        chk(q, st(3'h3, 4'h8));
        wait_hi(0, 40);
        chk(waited inside {[10:25]}, 1'b1);
        frame(1'b0, sa, 2'b00);
        chk(sua_req, 1'b0);
        apb(`TRP_OFF_ERRCNT, 1'b0, 32'h0);
        chk(q, 32'h1);
        apb(`TRP_OFF_ERRCNT, 1'b1, 32'h0);
        frame(1'b1, sb, 2'b10);
        chk(tx_poll_addr, sb);
        apb(`TRP_OFF_STATUS, 1'b0, 32'h0);
        chk(q, st(3'h3, 4'h0));
        wait_hi(2, 520);
        chk({waited > 480, discard_all}, 2'b11);
        pulse(0);
        chk(is_active, 1'b1);
        pulse(1);
        chk(amp_req, 1'b1);
        frame(1'b1, own, 2'b00);
        chk(single_station, 1'b1);
        apb(`TRP_OFF_STATUS, 1'b0, 32'h0);
        chk(q[2:0], 3'b111);
        frame(1'b0, rnd48(), 2'b01);
        chk({single_station, tx_poll_addr}, {1'b0, sb});
        wait_hi(1, 450);
        chk({waited > 150, tx_poll_addr}, {1'b1, sb});
        wait_hi(2, 200);
        chk(discard_all, 1'b0);
        pulse(2);
        chk({is_active, amp_req, smp_req}, 3'b000);
        pulse(0);
        frame(1'b1, rnd48(), 2'b00);
        chk({is_active, dup_req}, 2'b01);
        pulse(3);
        chk({amp_req, smp_req}, 2'b00);
        final_report();
    end
endmodule

/* File: testbench/trp_ring_model.sv */
`timescale 1ns/1ps
module trp_ring_model
#(
    parameter int DLY = 3
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [4:0] req,
    output logic [4:0] ack
);
    // Transmitter acks each queued frame DLY+1 cycles after its request and never reports success
    int cnt [5];
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ack <= 5'h00;
            foreach (cnt[i]) cnt[i] <= 0;
        end
        else
        begin
            for (int i = 0; i < 5; i++)
            begin
                ack[i] <= 1'b0;
                if (req[i] && !ack[i])
                begin
                    cnt[i] <= cnt[i] + 1;
                    if (cnt[i] == DLY)
                    begin
                        ack[i] <= 1'b1;
                        cnt[i] <= 0;
                    end
                end
                else if (!req[i])
                    cnt[i] <= 0;
            end
        end
    end
endmodule
